// File: hdl/pwm_pkg.sv
package pwm_pkg;

  // register indices; byte address is four times the index
  localparam logic [7:0] IDX_INTERRUPT_CONTROL = 8'h0B;
  localparam logic [7:0] IDX_PERIPHERAL_FLAGS  = 8'h0C;
  localparam logic [7:0] IDX_BASE_COUNTER      = 8'h11;
  localparam logic [7:0] IDX_BASE_TIMER_CTRL   = 8'h12;
  localparam logic [7:0] IDX_DUTY_SETPOINT     = 8'h15;
  localparam logic [7:0] IDX_DUTY_ACTIVE       = 8'h16;
  localparam logic [7:0] IDX_UNIT_CONTROL      = 8'h17;
  localparam logic [7:0] IDX_PORT_C_DIRECTION  = 8'h87;
  localparam logic [7:0] IDX_PERIPHERAL_ENA    = 8'h8C;
  localparam logic [7:0] IDX_PERIOD_LIMIT      = 8'h92;

  localparam int          ADDR_W     = 12;
  localparam logic [1:0]  ADDR_LANE  = 2'h0;
  localparam logic [1:0]  ADDR_HI0   = 2'h0;

  // reset values
  localparam logic [7:0] RST_ZERO   = 8'h00;
  localparam logic [7:0] RST_PERIOD = 8'hFF;
  localparam logic [5:0] RST_DIR    = 6'h3F;

  // field positions
  localparam int BIT_BASE_MATCH_FLAG = 1;
  localparam int BIT_PIN_DIRECTION   = 2;

  // prescaler terminal counts for divide by 1, 4 and 16
  localparam logic [3:0] PRE_LAST_1  = 4'h0;
  localparam logic [3:0] PRE_LAST_4  = 4'h3;
  localparam logic [3:0] PRE_LAST_16 = 4'hF;
  localparam logic [1:0] PRE_SEL_1   = 2'h0;
  localparam logic [1:0] PRE_SEL_4   = 2'h1;
  localparam logic [1:0] FINE_LAST   = 2'h3;
  localparam logic [1:0] MODE_PWM    = 2'h3;
  localparam logic [9:0] DUTY_ZERO   = 10'h000;

  typedef struct packed {
    logic [3:0] postscale;
    logic       run;
    logic [1:0] prescale;
  } timer_ctrl_s;

  typedef struct packed {
    logic [1:0] duty_lo;
    logic [1:0] mode_hi;
    logic [1:0] mode_lo;
  } unit_ctrl_s;

endpackage

// File: hdl/wrap_counter.sv
`timescale 1ns/100ps
module wrap_counter #(
  parameter int W = 4
) (
  // clock and reset
  input  wire logic         pclk,
  input  wire logic         presetn,
  // control
  input  wire logic         clr,
  input  wire logic         en,
  input  wire logic [W-1:0] last,
  // state
  output logic      [W-1:0] count,
  output logic              wrap
);

  // wrap also fires if count has run past a lowered terminal value
  assign wrap = en && (count >= last);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count <= '0;
    end else if (clr || wrap) begin
      count <= '0;
    end else if (en) begin
      count <= count + W'(1);
    end
  end

endmodule

// File: hdl/pwm_unit.sv
// Notes on behaviour
// - period is (period_limit+1) times four clocks times the prescale divisor
// - base_counter clears when it matches period_limit, starting a new period
// - match drives pwm_out high, unless the new duty value is zero
// - match copies duty setpoint and low bits into the active latch
// - postscaler only paces the match flag, never the pwm period
// - duty is duty_setpoint_high8 above unit_control bits 5:4
// - high time is duty value times one clock times prescale divisor
// - duty writes land any time but apply only at the next match
// - in pwm mode software writes to duty_active_latch are ignored
// - active latch plus hidden two bits double buffer the duty value
// - pin clears when active duty equals counter extended by fine bits
// - duty beyond the period never clears the pin, giving full duty
// - prescale divisors 1, 4 and 16 time both period and duty
// - unimplemented register bits read as zero
// - clearing unit_control forces the pwm output latch low
`timescale 1ns/100ps
module pwm_unit
  import pwm_pkg::*;
(
  // apb clock and reset
  input  wire logic                      pclk,
  input  wire logic                      presetn,
  // apb slave
  input  wire logic                      psel,
  input  wire logic                      penable,
  input  wire logic                      pwrite,
  input  wire logic [pwm_pkg::ADDR_W-1:0] paddr,
  input  wire logic [31:0]               pwdata,
  output logic      [31:0]               prdata,
  output logic                           pready,
  output logic                           pslverr,
  // pin
  output logic                           pwm_out,
  output logic                           pwm_oe
);

  import pwm_pkg::*;

  timer_ctrl_s base_timer_control;
  unit_ctrl_s  unit_control;
  logic [7:0]  interrupt_control;
  logic [7:0]  peripheral_flags;
  logic [7:0]  peripheral_enables;
  logic [7:0]  base_counter;
  logic [7:0]  period_limit;
  logic [7:0]  duty_setpoint_high8;
  logic [7:0]  duty_active_latch;
  logic [1:0]  duty_hidden_lo;
  logic [5:0]  port_c_direction;

  logic [7:0]  reg_idx;
  logic        addr_ok;
  logic        hit;
  logic        setup_rd;
  logic        wr;
  logic [7:0]  wbyte;
  logic [7:0]  next_rdata;

  logic        pwm_mode;
  logic        running;
  logic [3:0]  pre_last;
  logic [3:0]  pre_count;
  logic        pre_wrap;
  logic [1:0]  fine;
  logic        fine_wrap;
  logic [3:0]  post_count;
  logic        post_wrap;
  logic        counter_wr;
  logic        match;
  logic [9:0]  duty_next;
  logic [9:0]  duty_active;
  logic [9:0]  ext_count;
  logic [9:0]  next_ext;

  // apb decode
  assign reg_idx  = paddr[9:2];
  assign addr_ok  = (paddr[1:0] == ADDR_LANE) && (paddr[ADDR_W-1:10] == ADDR_HI0);
  assign setup_rd = psel && !penable && !pwrite;
  assign wr       = psel && penable && pwrite && hit;
  assign wbyte    = pwdata[7:0];
  // zero wait state: read data is captured in the setup cycle
  assign pready   = 1'b1;
  assign pslverr  = psel && penable && !hit;

  always_comb begin
    hit = addr_ok;
    next_rdata = RST_ZERO;
    case (reg_idx)
      IDX_INTERRUPT_CONTROL: next_rdata = interrupt_control;
      IDX_PERIPHERAL_FLAGS:  next_rdata = peripheral_flags;
      IDX_BASE_COUNTER:      next_rdata = base_counter;
      IDX_BASE_TIMER_CTRL:   next_rdata = {1'b0, base_timer_control};
      IDX_DUTY_SETPOINT:     next_rdata = duty_setpoint_high8;
      IDX_DUTY_ACTIVE:       next_rdata = duty_active_latch;
      IDX_UNIT_CONTROL:      next_rdata = {2'b00, unit_control};
      IDX_PORT_C_DIRECTION:  next_rdata = {2'b00, port_c_direction};
      IDX_PERIPHERAL_ENA:    next_rdata = peripheral_enables;
      IDX_PERIOD_LIMIT:      next_rdata = period_limit;
      default:               hit = 1'b0;
    endcase
    if (!addr_ok) begin
      next_rdata = RST_ZERO;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= '0;
    end else if (setup_rd) begin
      prdata <= {24'h000000, next_rdata};
    end
  end

  // plain storage registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      interrupt_control   <= RST_ZERO;
      peripheral_enables  <= RST_ZERO;
      period_limit        <= RST_PERIOD;
      duty_setpoint_high8 <= RST_ZERO;
      base_timer_control  <= '0;
      unit_control        <= '0;
      port_c_direction    <= RST_DIR;
    end else if (wr) begin
      case (reg_idx)
        IDX_INTERRUPT_CONTROL: interrupt_control   <= wbyte;
        IDX_PERIPHERAL_ENA:    peripheral_enables  <= wbyte;
        IDX_PERIOD_LIMIT:      period_limit        <= wbyte;
        IDX_DUTY_SETPOINT:     duty_setpoint_high8 <= wbyte;
        IDX_BASE_TIMER_CTRL:   base_timer_control  <= wbyte[6:0];
        IDX_UNIT_CONTROL:      unit_control        <= wbyte[5:0];
        IDX_PORT_C_DIRECTION:  port_c_direction    <= wbyte[5:0];
        default:               ;
      endcase
    end
  end

  // direction bit low makes the pin an output
  assign pwm_oe   = !port_c_direction[BIT_PIN_DIRECTION];
  assign pwm_mode = (unit_control.mode_hi == MODE_PWM);
  assign running  = base_timer_control.run;

  // prescale divisor, shared by period and duty timing
  always_comb begin
    case (base_timer_control.prescale)
      PRE_SEL_1: pre_last = PRE_LAST_1;
      PRE_SEL_4: pre_last = PRE_LAST_4;
      default:   pre_last = PRE_LAST_16;
    endcase
  end

  assign counter_wr = wr && (reg_idx == IDX_BASE_COUNTER);

  // a counter write also restarts the divider chain
  wrap_counter #(.W(4)) u_prescale (
    .pclk    (pclk),
    .presetn (presetn),
    .clr     (counter_wr),
    .en      (running),
    .last    (pre_last),
    .count   (pre_count),
    .wrap    (pre_wrap)
  );

  // fine bits: two bit count of prescaler wraps at every prescale setting
  wrap_counter #(.W(2)) u_fine (
    .pclk    (pclk),
    .presetn (presetn),
    .clr     (counter_wr || match),
    .en      (pre_wrap),
    .last    (FINE_LAST),
    .count   (fine),
    .wrap    (fine_wrap)
  );

  // postscaler paces only the match flag
  wrap_counter #(.W(4)) u_postscale (
    .pclk    (pclk),
    .presetn (presetn),
    .clr     (1'b0),
    .en      (match),
    .last    (base_timer_control.postscale),
    .count   (post_count),
    .wrap    (post_wrap)
  );

  // match ends the last fine step of the period_limit count
  assign match = fine_wrap && (base_counter == period_limit);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      base_counter <= RST_ZERO;
    end else if (counter_wr) begin
      base_counter <= wbyte;
    end else if (match) begin
      base_counter <= RST_ZERO;
    end else if (fine_wrap) begin
      base_counter <= base_counter + 8'h01;
    end
  end

  assign duty_next   = {duty_setpoint_high8, unit_control.duty_lo};
  assign duty_active = {duty_active_latch, duty_hidden_lo};
  assign ext_count   = {base_counter, fine};
  assign next_ext    = match ? DUTY_ZERO : (ext_count + 10'h001);

  // double buffer: software never touches the hidden low bits
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      duty_active_latch <= RST_ZERO;
      duty_hidden_lo    <= 2'b00;
    end else if (match) begin
      duty_active_latch <= duty_setpoint_high8;
      duty_hidden_lo    <= unit_control.duty_lo;
    end else if (wr && reg_idx == IDX_DUTY_ACTIVE && !pwm_mode) begin
      duty_active_latch <= wbyte;
    end
  end

  // output latch; a duty past the period never meets the compare
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pwm_out <= 1'b0;
    end else if (wr && reg_idx == IDX_UNIT_CONTROL && wbyte[5:0] == 6'h00) begin
      pwm_out <= 1'b0;
    end else if (pwm_mode && match) begin
      pwm_out <= (duty_next != DUTY_ZERO);
    end else if (pwm_mode && pre_wrap && next_ext == duty_active) begin
      pwm_out <= 1'b0;
    end
  end

  // match flag: hardware set wins over a software clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      peripheral_flags <= RST_ZERO;
    end else begin
      if (wr && reg_idx == IDX_PERIPHERAL_FLAGS) begin
        peripheral_flags <= wbyte;
      end
      if (post_wrap) begin
        peripheral_flags[BIT_BASE_MATCH_FLAG] <= 1'b1;
      end
    end
  end

  // helper: cycles since last match, for period length checks
  logic [13:0] since_match;
  logic        seen_match;
  logic [13:0] period_cycles;
  logic [4:0]  pre_div;

  assign pre_div       = {1'b0, pre_last} + 5'h01;
  assign period_cycles = 14'(({6'h00, period_limit} + 14'h0001) * 14'h0004 * {9'h000, pre_div});

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      since_match <= '0;
      seen_match  <= 1'b0;
    end else if (match || counter_wr || (wr && reg_idx == IDX_BASE_TIMER_CTRL)) begin
      since_match <= 14'h0001;
      seen_match  <= match;
    end else if (running) begin
      since_match <= since_match + 14'h0001;
    end
  end

  property p_period_len;
    @(posedge pclk) disable iff (!presetn)
    match && seen_match |-> since_match == period_cycles;
  endproperty
  a_period_len: assert property (p_period_len) else $error("period length wrong");

  property p_clear_on_match;
    @(posedge pclk) disable iff (!presetn)
    match && !counter_wr |=> base_counter == RST_ZERO && fine == 2'b00;
  endproperty
  a_clear_on_match: assert property (p_clear_on_match) else $error("counter not cleared");

  property p_set_on_match;
    @(posedge pclk) disable iff (!presetn)
    pwm_mode && match && !wr |=> pwm_out == ($past(duty_next) != DUTY_ZERO);
  endproperty
  a_set_on_match: assert property (p_set_on_match) else $error("pin wrong at match");

  property p_latch_duty;
    @(posedge pclk) disable iff (!presetn)
    match |=> duty_active == $past(duty_next);
  endproperty
  a_latch_duty: assert property (p_latch_duty) else $error("duty not latched");

  property p_hold_duty;
    @(posedge pclk) disable iff (!presetn)
    pwm_mode && !match |=> $stable(duty_active);
  endproperty
  a_hold_duty: assert property (p_hold_duty) else $error("duty changed mid period");

  property p_active_ro;
    @(posedge pclk) disable iff (!presetn)
    pwm_mode && wr && reg_idx == IDX_DUTY_ACTIVE && !match |=> $stable(duty_active_latch);
  endproperty
  a_active_ro: assert property (p_active_ro) else $error("active latch written");

  property p_clear_on_compare;
    @(posedge pclk) disable iff (!presetn)
    pwm_mode && !match && !wr && pre_wrap && next_ext == duty_active |=> !pwm_out;
  endproperty
  a_clear_on_compare: assert property (p_clear_on_compare) else $error("pin not cleared");

  property p_full_duty;
    @(posedge pclk) disable iff (!presetn)
    pwm_mode && pwm_out && !wr && duty_active > {period_limit, FINE_LAST}
      && ext_count <= {period_limit, FINE_LAST} && !match |=> pwm_out;
  endproperty
  a_full_duty: assert property (p_full_duty) else $error("full duty pin dropped");

  property p_ctrl_clear;
    @(posedge pclk) disable iff (!presetn)
    wr && reg_idx == IDX_UNIT_CONTROL && wbyte == RST_ZERO |=> !pwm_out;
  endproperty
  a_ctrl_clear: assert property (p_ctrl_clear) else $error("pin not forced low");

  property p_stopped;
    @(posedge pclk) disable iff (!presetn)
    !running && !wr |=> $stable(pwm_out) && $stable(base_counter) && !$past(match);
  endproperty
  a_stopped: assert property (p_stopped) else $error("stopped timer moved");

  property p_reserved_zero;
    @(posedge pclk) disable iff (!presetn)
    setup_rd && reg_idx == IDX_UNIT_CONTROL |=> prdata[31:6] == 26'h0;
  endproperty
  a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bits set");

  c_zero_duty: cover property (@(posedge pclk) disable iff (!presetn)
    pwm_mode && match && duty_next == DUTY_ZERO);
  c_full_duty: cover property (@(posedge pclk) disable iff (!presetn)
    pwm_mode && match && duty_active > {period_limit, FINE_LAST} ##1 pwm_out);
  c_mid_write: cover property (@(posedge pclk) disable iff (!presetn)
    pwm_mode && pwm_out && wr && reg_idx == IDX_DUTY_SETPOINT);
  c_flag_set: cover property (@(posedge pclk) disable iff (!presetn) post_wrap);

endmodule

// File: bench/pwm_load.sv
`timescale 1ns/100ps
module pwm_load (
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // pin from the unit
  input  wire logic        pwm_out,
  input  wire logic        pwm_oe,
  // what the load sees
  output logic             pin_level,
  output logic [15:0]      high_len,
  output logic [15:0]      period_len
);
  logic [15:0] run_high;
  logic [15:0] run_period;
  logic        prev;

  // released pin falls to the pull-down, never keeps the last level
  assign pin_level = pwm_oe & pwm_out;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prev       <= 1'b0;
      run_high   <= 16'h0000;
      run_period <= 16'h0000;
      high_len   <= 16'h0000;
      period_len <= 16'h0000;
    end else begin
      prev       <= pin_level;
      run_high   <= pin_level ? run_high + 16'h0001 : 16'h0000;
      run_period <= (pin_level && !prev) ? 16'h0001 : run_period + 16'h0001;
      if (prev && !pin_level) begin
        high_len <= run_high;
      end
      if (pin_level && !prev) begin
        period_len <= run_period;
      end
    end
  end
endmodule

// File: bench/tb_pwm_unit.sv
`timescale 1ns/100ps
module tb_pwm_unit;
  import pwm_pkg::*;
  logic                     pclk = 1'b0;
  logic                     presetn;
  logic                     psel;
  logic                     penable;
  logic                     pwrite;
  logic [ADDR_W-1:0]        paddr;
  logic [31:0]              pwdata;
  logic [31:0]              prdata;
  logic                     pready;
  logic                     pslverr;
  logic                     pwm_out;
  logic                     pwm_oe;
  logic                     pin_level;
  logic [15:0]              high_len;
  logic [15:0]              period_len;
  int                       err_total = 0;
  int                       samples_checked = 0;
  int                       cyc = 0;
  int                       waits = 0;
  int                       per;
  int                       h;
  logic [31:0]              d;
  logic [31:0]              d2;
  logic [7:0]               pl;
  logic [7:0]               nd;
  logic [9:0]               du;
  logic [1:0]               ps;
  logic [3:0]               post;
  logic                     e;
  logic [7:0]               ridx [5] = '{IDX_PERIOD_LIMIT, IDX_PORT_C_DIRECTION,
    IDX_UNIT_CONTROL, IDX_BASE_COUNTER, IDX_BASE_TIMER_CTRL};
  logic [7:0]               rexp [5] = '{RST_PERIOD, {2'h0, RST_DIR}, RST_ZERO,
    RST_ZERO, RST_ZERO};

  always #5 pclk = ~pclk;

  pwm_unit pwm_unit_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .pwm_out(pwm_out), .pwm_oe(pwm_oe));

  pwm_load pwm_load_inst (.pclk(pclk), .presetn(presetn), .pwm_out(pwm_out),
    .pwm_oe(pwm_oe), .pin_level(pin_level), .high_len(high_len),
    .period_len(period_len));

  task automatic conclude();
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // hang guard; the full run needs well under a third of this
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      err_total++;
      conclude();
    end
  end

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] idx, input logic [31:0] wd,
                     output logic [31:0] rdat, output logic er);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= {ADDR_HI0, idx, ADDR_LANE};
    pwdata  <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) begin
      waits++;
      @(posedge pclk);
    end
    rdat = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] idx, input logic [7:0] v);
    logic [31:0] x;
    logic        y;
    apb(1'b1, idx, {24'h000000, v}, x, y);
  endtask

  task automatic rd(input logic [7:0] idx, output logic [31:0] x);
    logic y;
    apb(1'b0, idx, 32'h00000000, x, y);
  endtask

  task automatic count_high(input int n, output int c);
    c = 0;
    repeat (n) begin
      @(posedge pclk);
      c += (pin_level === 1'b1);
    end
  endtask

  function automatic int divf(input logic [1:0] p);
    return (p == PRE_SEL_1) ? 1 : (p == PRE_SEL_4) ? 4 : 16;
  endfunction

  // setup order as software must follow it; timer stopped and cleared first
  task automatic cfg();
    wr(IDX_BASE_TIMER_CTRL, 8'h00);
    wr(IDX_BASE_COUNTER, 8'h00);
    wr(IDX_PERIOD_LIMIT, pl);
    wr(IDX_DUTY_SETPOINT, du[9:2]);
    wr(IDX_UNIT_CONTROL, {2'h0, du[1:0], 4'h0});
    wr(IDX_PORT_C_DIRECTION, 8'h3B);
    wr(IDX_BASE_TIMER_CTRL, {1'b0, post, 1'b1, ps});
    wr(IDX_UNIT_CONTROL, {2'h0, du[1:0], 4'hC});
    per = (int'(pl) + 1) * 4 * divf(ps);
    repeat (3 * per + 8) @(posedge pclk);
  endtask

  initial begin
    presetn = 1'b0;
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = '0;
    pwdata  = 32'h00000000;
    void'($urandom(36682));
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 5; i++) begin
      apb(1'b0, ridx[i], 32'h00000000, d, e);
      check("reset value", d, {24'h000000, rexp[i]});
      check("mapped error", {31'h0, e}, 32'h00000000);
    end
    check("oe at reset", {31'h0, pwm_oe}, 32'h00000000);
    apb(1'b0, 8'h40, 32'h00000000, d, e);
    check("unmapped error", {31'h0, e}, 32'h00000001);
    check("unmapped data", d, 32'h00000000);
    wr(IDX_UNIT_CONTROL, 8'hFF);
    rd(IDX_UNIT_CONTROL, d);
    check("unit_control bits", d, 32'h0000003F);
    wr(IDX_UNIT_CONTROL, 8'h00);
    wr(IDX_PORT_C_DIRECTION, 8'hFF);
    rd(IDX_PORT_C_DIRECTION, d);
    check("direction bits", d, 32'h0000003F);
    // fixed case first, then random periods and duties in every prescale
    for (int i = 0; i < 8; i++) begin
      ps   = 2'(i % 4);
      post = 4'($urandom_range(15, 1));
      pl   = (i == 0) ? 8'h00 : 8'($urandom_range(7, 1));
      // duty kept inside the period; resolution is log2 of prescaled clocks per period
      du   = (i == 0) ? 10'h002 : 10'($urandom_range(int'(pl) * 4 + 3, 1));
      cfg();
      check("oe", {31'h0, pwm_oe}, 32'h00000001);
      check("period", {16'h0, period_len}, 32'(per));
      check("high time", {16'h0, high_len}, 32'(int'(du) * divf(ps)));
    end
    wr(IDX_BASE_TIMER_CTRL, {1'b0, post, 1'b0, ps});
    rd(IDX_BASE_COUNTER, d);
    h = 0;
    count_high(50, h);
    rd(IDX_BASE_COUNTER, d2);
    check("stopped counter", d2, d);
    check("stopped pin", 32'(h), (pin_level === 1'b1) ? 32'h00000032 : 32'h00000000);
    nd = 8'($urandom_range(int'(pl), 1));
    wr(IDX_DUTY_SETPOINT, nd);
    rd(IDX_DUTY_ACTIVE, d);
    check("active before match", d, {24'h0, du[9:2]});
    wr(IDX_BASE_TIMER_CTRL, {1'b0, post, 1'b1, ps});
    repeat (2 * per + 8) @(posedge pclk);
    rd(IDX_DUTY_ACTIVE, d);
    check("active after match", d, {24'h0, nd});
    check("new high time", {16'h0, high_len}, 32'(int'({nd, du[1:0]}) * divf(ps)));
    wr(IDX_DUTY_ACTIVE, ~nd);
    rd(IDX_DUTY_ACTIVE, d);
    check("active read only", d, {24'h0, nd});
    rd(IDX_BASE_COUNTER, d);
    check("counter in range", {31'h0, d[7:0] <= pl}, 32'h00000001);
    wr(IDX_DUTY_SETPOINT, 8'hFF);
    repeat (2 * per + 8) @(posedge pclk);
    count_high(per, h);
    check("full duty", 32'(h), 32'(per));
    wr(IDX_UNIT_CONTROL, 8'h00);
    @(posedge pclk);
    check("cleared latch", {31'h0, pwm_out}, 32'h00000000);
    count_high(per, h);
    check("stays low", 32'(h), 32'h00000000);
    du = 10'h000;
    cfg();
    count_high(2 * per, h);
    check("zero duty", 32'(h), 32'h00000000);
    // slave promises zero wait states on every access
    check("wait states", 32'(waits), 32'h00000000);
    conclude();
  end
endmodule
